/* hw/clcr_regs.v */
// Charger, indicator and main converter control registers
`timescale 1ns/1ps
`include "clcr_defines.vh"

module clcr_regs #(
    parameter TICK_CYCLES = `CLCR_TICK_CYCLES
) (
    clk,
    rst_b,
    reg_addr,
    reg_wdata,
    reg_we,
    reg_rdata,
    adapter_valid,
    usb_valid,
    sleep_request_pin,
    primary_voltage_default_pin,
    main_converter_enabled,
    charger_indicator_req,
    charge_indicator_pin_i,
    second_indicator_pin_i,
    charger_restart,
    fast_timer_en,
    charge_current_sel,
    charge_current_pct,
    usb_limit_500,
    charge_from_adapter,
    charge_from_usb,
    force_fixed_frequency,
    undervoltage_threshold_sel,
    supply_enable,
    low_power_engaged,
    main_discharge_on,
    main_voltage_sel,
    charge_indicator_pin_o,
    charge_indicator_pin_oe,
    second_indicator_pin_o,
    second_indicator_pin_oe
);
    input wire clk;
    input wire rst_b;
    input wire [7:0] reg_addr;
    input wire [7:0] reg_wdata;
    input wire reg_we;
    output reg [7:0] reg_rdata;
    input wire adapter_valid;
    input wire usb_valid;
    input wire sleep_request_pin;
    input wire primary_voltage_default_pin;
    input wire main_converter_enabled;
    input wire charger_indicator_req;
    input wire charge_indicator_pin_i;
    input wire second_indicator_pin_i;
    output reg charger_restart;
    output reg fast_timer_en;
    output reg [1:0] charge_current_sel;
    output reg [6:0] charge_current_pct;
    output reg usb_limit_500;
    output reg charge_from_adapter;
    output reg charge_from_usb;
    output reg force_fixed_frequency;
    output reg [1:0] undervoltage_threshold_sel;
    output reg supply_enable;
    output reg low_power_engaged;
    output reg main_discharge_on;
    output reg [1:0] main_voltage_sel;
    output reg charge_indicator_pin_o;
    output reg charge_indicator_pin_oe;
    output reg second_indicator_pin_o;
    output reg second_indicator_pin_oe;

    localparam integer TICK_LAST_FULL = TICK_CYCLES - 1;
    localparam [20:0] TICK_LAST = TICK_LAST_FULL[20:0];

    reg [7:0] charger_configuration_reg;
    reg [7:0] indicator1_on_time_reg;
    reg [7:0] indicator1_period_reg;
    reg [7:0] indicator2_on_time_reg;
    reg [7:0] indicator2_period_reg;
    reg [7:0] main_converter_control_reg;
    reg [7:0] rdata_next;

    // Pin inputs pass two flops; stage one is read only by stage two
    reg [4:0] pin_meta_reg;
    reg [4:0] pin_sync_reg;
    wire adapter_ok;
    wire usb_ok;
    wire sleep_req;
    wire default_sel;
    wire main_on;

    reg [1:0] strap_cnt_reg;
    reg strap_done_reg;
    reg main_vsel_written_reg;

    reg [20:0] tick_cnt_reg;
    reg tick_reg;
    reg ind1_restart_reg;
    reg ind2_restart_reg;
    wire ind1_blink;
    wire ind2_blink;
    wire [1:0] ind1_mode;
    wire [1:0] ind2_mode;

    wire wr_chg;
    wire wr_ind1;
    wire wr_ind2;
    wire wr_main;

    // Charge current code to percent of the resistor-set maximum
    function [6:0] clcr_cur_pct;
        input [1:0] code;
        begin
            case (code)
                2'h3: clcr_cur_pct = 7'h64;
                2'h2: clcr_cur_pct = 7'h4B;
                2'h1: clcr_cur_pct = 7'h32;
                default: clcr_cur_pct = 7'h19;
            endcase
        end
    endfunction

    // Mode decode to transistor conduct; charger mode only where allowed
    function clcr_ind_drive;
        input [1:0] mode;
        input has_charger_mode;
        input blink;
        input charger_req;
        begin
            case (mode)
                `CLCR_MODE_CHARGER: clcr_ind_drive = has_charger_mode &
                                                     charger_req;
                `CLCR_MODE_BLINK: clcr_ind_drive = blink;
                `CLCR_MODE_ON: clcr_ind_drive = 1'b1;
                default: clcr_ind_drive = 1'b0;
            endcase
        end
    endfunction

    assign adapter_ok = pin_sync_reg[0];
    assign usb_ok = pin_sync_reg[1];
    assign sleep_req = pin_sync_reg[2];
    assign default_sel = pin_sync_reg[3];
    assign main_on = pin_sync_reg[4];

    assign wr_chg = reg_we && (reg_addr == `CLCR_ADDR_CHG_CFG);
    assign wr_ind1 = reg_we && ((reg_addr == `CLCR_ADDR_IND1_ON) ||
                                (reg_addr == `CLCR_ADDR_IND1_PER));
    assign wr_ind2 = reg_we && ((reg_addr == `CLCR_ADDR_IND2_ON) ||
                                (reg_addr == `CLCR_ADDR_IND2_PER));
    assign wr_main = reg_we && (reg_addr == `CLCR_ADDR_MAIN_CTL);

    assign ind1_mode = {indicator1_on_time_reg[`CLCR_IND_MODE_BIT],
                        indicator1_period_reg[`CLCR_IND_MODE_BIT]};
    assign ind2_mode = {indicator2_on_time_reg[`CLCR_IND_MODE_BIT],
                        indicator2_period_reg[`CLCR_IND_MODE_BIT]};

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
        end else begin
            pin_meta_reg <= {main_converter_enabled,
                             primary_voltage_default_pin, sleep_request_pin,
                             usb_valid, adapter_valid};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Register writes
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            charger_configuration_reg <= `CLCR_RST_CHG_CFG;
            indicator1_on_time_reg <= `CLCR_RST_IND;
            indicator1_period_reg <= `CLCR_RST_IND;
            indicator2_on_time_reg <= `CLCR_RST_IND;
            indicator2_period_reg <= `CLCR_RST_IND;
            main_converter_control_reg <= `CLCR_RST_MAIN_CTL;
            main_vsel_written_reg <= 1'b0;
        end else begin
            if (wr_chg) begin
                charger_configuration_reg <= reg_wdata;
            end
            if (reg_we && (reg_addr == `CLCR_ADDR_IND1_ON)) begin
                indicator1_on_time_reg <= reg_wdata;
            end
            if (reg_we && (reg_addr == `CLCR_ADDR_IND1_PER)) begin
                indicator1_period_reg <= reg_wdata;
            end
            if (reg_we && (reg_addr == `CLCR_ADDR_IND2_ON)) begin
                indicator2_on_time_reg <= reg_wdata;
            end
            if (reg_we && (reg_addr == `CLCR_ADDR_IND2_PER)) begin
                indicator2_period_reg <= reg_wdata;
            end
            if (wr_main) begin
                main_converter_control_reg <= reg_wdata;
                main_vsel_written_reg <= 1'b1;
            end else if (strap_done_reg == 1'b0 && strap_cnt_reg == 2'h3 &&
                         !main_vsel_written_reg) begin
                main_converter_control_reg[`CLCR_MAIN_VSEL_LO] <=
                    default_sel;
            end
        end
    end

    // Strap is taken once the synchroniser has filled after release
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (strap_cnt_reg != 2'h3) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
        end else begin
            strap_done_reg <= 1'b1;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_reg <= 21'h000000;
            tick_reg <= 1'b0;
        end else if (tick_cnt_reg >= TICK_LAST) begin
            tick_cnt_reg <= 21'h000000;
            tick_reg <= 1'b1;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 21'h000001;
            tick_reg <= 1'b0;
        end
    end

    // any write to mode or timing restarts that cycle
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ind1_restart_reg <= 1'b0;
            ind2_restart_reg <= 1'b0;
        end else begin
            ind1_restart_reg <= wr_ind1;
            ind2_restart_reg <= wr_ind2;
        end
    end

    // on-time in 10 ms steps; period in 100 ms steps
    clcr_blink u_blink1 (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick_reg),
        .restart(ind1_restart_reg),
        .on_time(indicator1_on_time_reg[`CLCR_IND_TIME_HI:0]),
        .period(indicator1_period_reg[`CLCR_IND_TIME_HI:0]),
        .conduct(ind1_blink)
    );

    // second period field scaled as the first
    clcr_blink u_blink2 (
        .clk(clk),
        .rst_b(rst_b),
        .tick(tick_reg),
        .restart(ind2_restart_reg),
        .on_time(indicator2_on_time_reg[`CLCR_IND_TIME_HI:0]),
        .period(indicator2_period_reg[`CLCR_IND_TIME_HI:0]),
        .conduct(ind2_blink)
    );

    // Outputs, all registered
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            charger_restart <= 1'b0;
            fast_timer_en <= 1'b0;
            charge_current_sel <= 2'h3;
            charge_current_pct <= 7'h64;
            usb_limit_500 <= 1'b0;
            charge_from_adapter <= 1'b0;
            charge_from_usb <= 1'b0;
            force_fixed_frequency <= 1'b0;
            undervoltage_threshold_sel <= 2'h3;
            supply_enable <= 1'b1;
            low_power_engaged <= 1'b0;
            main_discharge_on <= 1'b0;
            main_voltage_sel <= 2'h2;
            charge_indicator_pin_o <= 1'b0;
            charge_indicator_pin_oe <= 1'b0;
            second_indicator_pin_o <= 1'b0;
            second_indicator_pin_oe <= 1'b0;
        end else begin
            // restart held while bit is set
            charger_restart <=
                charger_configuration_reg[`CLCR_CHG_RESTART];
            fast_timer_en <= charger_configuration_reg[`CLCR_CHG_FAST_TMR];
            charge_current_sel <=
                charger_configuration_reg[`CLCR_CHG_CUR_HI:`CLCR_CHG_CUR_LO];
            charge_current_pct <= clcr_cur_pct(
                charger_configuration_reg[`CLCR_CHG_CUR_HI:`CLCR_CHG_CUR_LO]);
            usb_limit_500 <= charger_configuration_reg[`CLCR_CHG_USB_500] &
                             charger_configuration_reg[`CLCR_CHG_USB_OK];
            // adapter wins when both are valid
            charge_from_adapter <= charger_configuration_reg[`CLCR_CHG_EN] &
                                   adapter_ok;
            charge_from_usb <= charger_configuration_reg[`CLCR_CHG_EN] &
                               charger_configuration_reg[`CLCR_CHG_USB_OK] &
                               usb_ok & !adapter_ok;
            force_fixed_frequency <=
                main_converter_control_reg[`CLCR_MAIN_FFREQ];
            undervoltage_threshold_sel <= main_converter_control_reg[
                `CLCR_MAIN_UVLO_HI:`CLCR_MAIN_UVLO_LO];
            // Bit is stored and driven; clearing it is a host fault
            supply_enable <= main_converter_control_reg[`CLCR_MAIN_SUPPLY];
            // pin gated by the enable bit
            low_power_engaged <=
                main_converter_control_reg[`CLCR_MAIN_LP_GATE] & sleep_req;
            // discharge only while converter is off
            main_discharge_on <=
                main_converter_control_reg[`CLCR_MAIN_DISCH] & !main_on;
            main_voltage_sel <= main_converter_control_reg[
                `CLCR_MAIN_VSEL_HI:`CLCR_MAIN_VSEL_LO];
            // Open drain: data low, enable while conducting
            charge_indicator_pin_o <= 1'b0;
            charge_indicator_pin_oe <= clcr_ind_drive(ind1_mode, 1'b1,
                                           ind1_blink, charger_indicator_req);
            second_indicator_pin_o <= 1'b0;
            second_indicator_pin_oe <= clcr_ind_drive(ind2_mode, 1'b0,
                                           ind2_blink, 1'b0);
        end
    end

    // Read mux; unmapped offsets read zero
    always @* begin
        case (reg_addr)
            `CLCR_ADDR_CHG_CFG: rdata_next = charger_configuration_reg;
            `CLCR_ADDR_IND1_ON: rdata_next = indicator1_on_time_reg;
            `CLCR_ADDR_IND1_PER: rdata_next = indicator1_period_reg;
            `CLCR_ADDR_IND2_ON: rdata_next = indicator2_on_time_reg;
            `CLCR_ADDR_IND2_PER: rdata_next = indicator2_period_reg;
            `CLCR_ADDR_MAIN_CTL: rdata_next = main_converter_control_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_next;
        end
    end
endmodule

/* pkg/clcr_defines.vh */
// Register offsets, field positions, reset values and timing for clcr
`ifndef CLCR_DEFINES_VH
`define CLCR_DEFINES_VH

`define CLCR_ADDR_CHG_CFG 8'h07
`define CLCR_ADDR_IND1_ON 8'h08
`define CLCR_ADDR_IND1_PER 8'h09
`define CLCR_ADDR_IND2_ON 8'h0A
`define CLCR_ADDR_IND2_PER 8'h0B
`define CLCR_ADDR_MAIN_CTL 8'h0C

`define CLCR_RST_CHG_CFG 8'h1B
`define CLCR_RST_IND 8'h00
// Bit 0 is replaced by the default-select pin after reset
`define CLCR_RST_MAIN_CTL 8'h72

`define CLCR_CHG_RESTART 6
`define CLCR_CHG_FAST_TMR 5
`define CLCR_CHG_CUR_HI 4
`define CLCR_CHG_CUR_LO 3
`define CLCR_CHG_USB_500 2
`define CLCR_CHG_USB_OK 1
`define CLCR_CHG_EN 0

`define CLCR_IND_MODE_BIT 7
`define CLCR_IND_TIME_HI 6

`define CLCR_MAIN_FFREQ 7
`define CLCR_MAIN_UVLO_HI 6
`define CLCR_MAIN_UVLO_LO 5
`define CLCR_MAIN_SUPPLY 4
`define CLCR_MAIN_LP_GATE 3
`define CLCR_MAIN_DISCH 2
`define CLCR_MAIN_VSEL_HI 1
`define CLCR_MAIN_VSEL_LO 0

`define CLCR_MODE_CHARGER 2'h0
`define CLCR_MODE_BLINK 2'h1
`define CLCR_MODE_OFF 2'h2
`define CLCR_MODE_ON 2'h3

`define CLCR_CLK_PERIOD_NS 8
`define CLCR_ON_STEP_MS 10
`define CLCR_PER_STEP_MS 100
`define CLCR_TICK_CYCLES ((`CLCR_ON_STEP_MS * 1000000) / `CLCR_CLK_PERIOD_NS)
`define CLCR_TICKS_PER_PER (`CLCR_PER_STEP_MS / `CLCR_ON_STEP_MS)

`endif

/* hw/clcr_blink.v */
// Blink timer for one open-drain indicator, counted in 10 ms ticks
`timescale 1ns/1ps
`include "clcr_defines.vh"

module clcr_blink (
    clk,
    rst_b,
    tick,
    restart,
    on_time,
    period,
    conduct
);
    input wire clk;
    input wire rst_b;
    input wire tick;
    input wire restart;
    input wire [6:0] on_time;
    input wire [6:0] period;
    output reg conduct;

    reg [10:0] elapsed_reg;
    wire [6:0] on_units;
    wire [6:0] per_code;
    wire [10:0] cycle_len;
    wire [31:0] cycle_prod;

    // Code zero gives the documented minimum of one step
    assign on_units = (on_time == 7'h00) ? 7'h01 : on_time;
    assign per_code = (period == 7'h00) ? 7'h01 : period;
    // Product is at most 1270 ticks, so eleven bits hold it
    assign cycle_prod = per_code * `CLCR_TICKS_PER_PER;
    assign cycle_len = cycle_prod[10:0];

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            elapsed_reg <= 11'h000;
            conduct <= 1'b0;
        end else if (restart) begin
            elapsed_reg <= 11'h000;
            conduct <= 1'b0;
        end else begin
            if (tick) begin
                if (elapsed_reg >= cycle_len - 11'h001) begin
                    elapsed_reg <= 11'h000;
                end else begin
                    elapsed_reg <= elapsed_reg + 11'h001;
                end
            end
            conduct <= (elapsed_reg < {4'h0, on_units});
        end
    end
endmodule

/* sim/clcr_chk.sv */
// Concurrent checks on the clcr register bank ports
`timescale 1ns/1ps

module clcr_chk (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_we,
    input wire charger_restart,
    input wire fast_timer_en,
    input wire [1:0] charge_current_sel,
    input wire [6:0] charge_current_pct,
    input wire usb_limit_500,
    input wire charge_from_adapter,
    input wire charge_from_usb,
    input wire force_fixed_frequency,
    input wire [1:0] undervoltage_threshold_sel,
    input wire low_power_engaged,
    input wire main_discharge_on,
    input wire [1:0] main_voltage_sel,
    input wire charge_indicator_pin_o,
    input wire charge_indicator_pin_oe,
    input wire second_indicator_pin_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_cfg_restart;
        logic [7:0] d;
        (reg_we && reg_addr == 8'h07, d = reg_wdata) |-> ##2
            charger_restart == d[6];
    endproperty
    a_cfg_restart: assert property (p_cfg_restart) else $error("restart bit");

    property p_cfg_fields;
        logic [7:0] d;
        (reg_we && reg_addr == 8'h07, d = reg_wdata) |-> ##2
            fast_timer_en == d[5] && charge_current_sel == d[4:3];
    endproperty
    a_cfg_fields: assert property (p_cfg_fields) else $error("cfg fields");

    property p_pct;
        charge_current_pct == (charge_current_sel == 2'h3 ? 7'h64 :
            charge_current_sel == 2'h2 ? 7'h4B :
            charge_current_sel == 2'h1 ? 7'h32 : 7'h19);
    endproperty
    a_pct: assert property (p_pct) else $error("current percent");

    property p_usb500;
        logic [7:0] d;
        (reg_we && reg_addr == 8'h07, d = reg_wdata) |-> ##2
            usb_limit_500 == (d[2] & d[1]);
    endproperty
    a_usb500: assert property (p_usb500) else $error("usb limit");

    property p_usb_gate;
        (reg_we && reg_addr == 8'h07 && !reg_wdata[1]) |-> ##2 !charge_from_usb;
    endproperty
    a_usb_gate: assert property (p_usb_gate) else $error("usb gate");

    property p_chg_off;
        (reg_we && reg_addr == 8'h07 && !reg_wdata[0]) |-> ##2
            !charge_from_adapter && !charge_from_usb;
    endproperty
    a_chg_off: assert property (p_chg_off) else $error("charge off");

    property p_src_excl;
        !(charge_from_adapter && charge_from_usb);
    endproperty
    a_src_excl: assert property (p_src_excl) else $error("two sources");

    property p_main;
        logic [7:0] d;
        (reg_we && reg_addr == 8'h0C, d = reg_wdata) |-> ##2
            {force_fixed_frequency, undervoltage_threshold_sel,
            main_voltage_sel} == {d[7:5], d[1:0]};
    endproperty
    a_main: assert property (p_main) else $error("main fields");

    property p_lp_gate;
        (reg_we && reg_addr == 8'h0C && !reg_wdata[3]) |-> ##2 !low_power_engaged;
    endproperty
    a_lp_gate: assert property (p_lp_gate) else $error("low power");

    property p_disch;
        (reg_we && reg_addr == 8'h0C && !reg_wdata[2]) |-> ##2 !main_discharge_on;
    endproperty
    a_disch: assert property (p_disch) else $error("discharge");

    property p_open_drain;
        !charge_indicator_pin_o && !second_indicator_pin_o;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin drive");

    c_restart: cover property (charger_restart);
    c_blink: cover property ($rose(charge_indicator_pin_oe));
    c_usb: cover property (charge_from_usb);
endmodule

/* sim/clcr_host.sv */
// Host side of the register write and read path
`timescale 1ns/1ps

module clcr_host (
    input wire clk,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_we,
    input wire [7:0] reg_rdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_we = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if (a == 8'h0C) v[4] = 1'b1;
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_we <= 1'b1;
        @(posedge clk);
        reg_we <= 1'b0;
        // Stale data would hide a late sample
        reg_wdata <= ~v;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1 d = reg_rdata;
    endtask
endmodule

/* sim/charger_led_converter_ctrl_regs_test.sv */
// Self-checking bench for the clcr register bank
`timescale 1ns/1ps

module charger_led_converter_ctrl_regs_test;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic adapter_valid = 1'b0;
    logic usb_valid = 1'b0;
    logic sleep_request_pin = 1'b0;
    logic primary_voltage_default_pin = 1'b1;
    logic main_converter_enabled = 1'b1;
    logic charger_indicator_req = 1'b1;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire reg_we, charger_restart, fast_timer_en, usb_limit_500;
    wire [1:0] charge_current_sel, undervoltage_threshold_sel, main_voltage_sel;
    wire [6:0] charge_current_pct;
    wire charge_from_adapter, charge_from_usb, force_fixed_frequency;
    wire supply_enable, low_power_engaged, main_discharge_on;
    wire charge_indicator_pin_o, charge_indicator_pin_oe;
    wire second_indicator_pin_o, second_indicator_pin_oe;
    // Pulled-up open-drain pins
    wire charge_indicator_pin_i = ~charge_indicator_pin_oe;
    wire second_indicator_pin_i = ~second_indicator_pin_oe;
    int mismatches = 0;
    int num_checks = 0;

    always #4 clk = ~clk;

    clcr_regs #(.TICK_CYCLES(4)) clcr_regs_i (.*);
    clcr_host clcr_host_i (.*);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic count_on(output logic [15:0] c1, output logic [15:0] c2);
        c1 = 16'h0000;
        c2 = 16'h0000;
        repeat (400) begin
            @(posedge clk);
            #1;
            c1 = c1 + charge_indicator_pin_oe;
            c2 = c2 + second_indicator_pin_oe;
        end
    endtask

    task automatic set_ind(input logic [7:0] base, input logic [1:0] m,
                           input logic [6:0] on, input logic [6:0] per);
        clcr_host_i.wr(base, {m[1], on});
        clcr_host_i.wr(base + 8'h01, {m[0], per});
        wait_clk(8);
    endtask

    task automatic t_reset;
        logic [7:0] d;
        clcr_host_i.rd(8'h07, d);
        chk(d, 8'h1B);
        for (int a = 8; a < 12; a++) begin
            clcr_host_i.rd(a[7:0], d);
            chk(d, 8'h00);
        end
        clcr_host_i.rd(8'h0C, d);
        chk(d, 8'h73);
        clcr_host_i.rd(8'h0D, d);
        chk(d, 8'h00);
        chk(main_voltage_sel, 2'h3);
        chk(fast_timer_en, 1'b0);
    endtask

    task automatic t_charger;
        logic [7:0] d;
        for (int c = 0; c < 4; c++) begin
            clcr_host_i.wr(8'h07, {3'b000, c[1:0], 3'b011});
            wait_clk(2);
            chk(charge_current_pct, 16'(25 * (c + 1)));
        end
        // Set, then software clears
        clcr_host_i.wr(8'h07, 8'h5B);
        wait_clk(2);
        chk(charger_restart, 1'b1);
        clcr_host_i.wr(8'h07, 8'h3B);
        wait_clk(2);
        chk({charger_restart, fast_timer_en}, 2'b01);
        clcr_host_i.rd(8'h07, d);
        chk(d, 8'h3B);
        @(posedge clk) usb_valid <= 1'b1;
        clcr_host_i.wr(8'h07, 8'h07);
        wait_clk(4);
        chk({charge_from_usb, usb_limit_500}, 2'b11);
        clcr_host_i.wr(8'h07, 8'h05);
        wait_clk(2);
        chk({charge_from_usb, usb_limit_500}, 2'b00);
        clcr_host_i.wr(8'h07, 8'h03);
        wait_clk(2);
        chk({charge_from_usb, usb_limit_500}, 2'b10);
        @(posedge clk) adapter_valid <= 1'b1;
        wait_clk(4);
        chk({charge_from_adapter, charge_from_usb}, 2'b10);
        clcr_host_i.wr(8'h07, 8'h02);
        wait_clk(2);
        chk({charge_from_adapter, charge_from_usb}, 2'b00);
    endtask

    task automatic t_main;
        for (int c = 0; c < 4; c++) begin
            clcr_host_i.wr(8'h0C, {c[0], c[1:0], 3'b100, ~c[1:0]});
            wait_clk(2);
            chk({force_fixed_frequency, undervoltage_threshold_sel,
                 main_voltage_sel, supply_enable},
                {c[0], c[1:0], ~c[1:0], 1'b1});
        end
        @(posedge clk) sleep_request_pin <= 1'b1;
        clcr_host_i.wr(8'h0C, 8'h18);
        wait_clk(4);
        chk(low_power_engaged, 1'b1);
        clcr_host_i.wr(8'h0C, 8'h14);
        wait_clk(4);
        chk({low_power_engaged, main_discharge_on}, 2'b00);
        @(posedge clk) main_converter_enabled <= 1'b0;
        wait_clk(4);
        chk(main_discharge_on, 1'b1);
        clcr_host_i.wr(8'h0C, 8'h10);
        wait_clk(2);
        chk(main_discharge_on, 1'b0);
    endtask

    task automatic t_blink;
        logic [15:0] c1, c2;
        logic [1:0] m;
        // Ten-tick cycle of 40 clocks, two ticks on
        set_ind(8'h08, 2'b01, 7'd2, 7'd1);
        count_on(c1, c2);
        chk(c1, 16'd80);
        chk(c2, 16'd0);
        set_ind(8'h08, 2'b01, 7'd0, 7'd0);
        set_ind(8'h0A, 2'b01, 7'd1, 7'd2);
        count_on(c1, c2);
        chk(c1, 16'd40);
        chk(c2, 16'd20);
        for (int k = 0; k < 3; k++) begin
            m = (k == 0) ? 2'b00 : (k == 1) ? 2'b10 : 2'b11;
            set_ind(8'h08, m, 7'd2, 7'd1);
            set_ind(8'h0A, m, 7'd2, 7'd1);
            count_on(c1, c2);
            chk(c1, (m == 2'b10) ? 16'd0 : 16'd400);
            chk(c2, (m == 2'b11) ? 16'd400 : 16'd0);
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        wait_clk(1);
        t_reset;
        t_charger;
        t_main;
        t_blink;
        print_verdict;
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        print_verdict;
    end
endmodule

bind clcr_regs clcr_chk clcr_chk_i (.*);
